//--- design/tws_top.sv
// Two-wire slave flag and clock-hold logic of the usable serial instance.
`timescale 1ns/1ps
// Notes on behaviour
// - The transmit-collision flag clears on a plain START but survives a repeated START.
// - A stop/address flag clear in the cycle of an address set leaves the clock hold on and SCL held.
// - A timeout in the same cycle as a detected START drops that transaction.
// - The data flag clears one cycle after the response command 0b11, so a read right after shows it set.
// - Only the first instance is present; the second reports itself absent.
//
// The block keeps the slave-side flags and the SCL clock hold of the usable serial instance.
// The front end turns the pin levels into START, repeated START, STOP and timeout events.
// The flag logic here reproduces the known flaws of this revision on purpose, so that
// software written against it meets the same hazards as on silicon.
// There is no register bus: every control and status bit is a plain port.
// A write-one clear arrives as a one-cycle pulse on its own port.
module tws_top #(
    parameter int TMO_CYCLES = tws_pkg::TMO_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    input  wire logic       timeout_en,
    input  wire logic       addr_match,
    input  wire logic       data_event,
    input  wire logic       tx_collision,
    input  wire logic [1:0] slave_cmd,
    input  wire logic       slave_cmd_wr,
    input  wire logic       stop_addr_clr,
    input  wire logic       tx_coll_clr,
    output logic            stop_addr_irq_flag,
    output logic            data_irq_flag,
    output logic            tx_coll_flag,
    output logic            clock_stretch_hold,
    output logic [1:0]      bus_state_field,
    output logic            drop_event,
    output logic            first_serial_instance,
    output logic            second_serial_instance
);
    tws_if ev ();
    tws_front #(
        .TMO_CYCLES (TMO_CYCLES)
    ) u_front (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .timeout_en (timeout_en),
        .ev         (ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The front end refuses the same values; checking here too raises the same message from the top.
    if (TMO_CYCLES < 1) begin : g_bad_tmo
        $error("timeout count must be at least one");
    end

    tws_pkg::tws_state_t state_reg;
    tws_pkg::tws_state_t state_next;
    logic                stop_addr_reg;
    logic                data_flag_reg;
    logic                txc_reg;
    logic                hold_reg;
    logic                lock_reg;
    logic                data_clr_reg;
    logic                drop_reg;
    logic                addr_set;
    logic                lock_hit;
    logic                resp_cmd;
    logic                drop_hit;

    // An address only counts inside a live transaction.
    assign addr_set = addr_match && (state_reg == tws_pkg::TWS_ADDR);
    assign lock_hit = addr_set && stop_addr_clr;
    assign resp_cmd = slave_cmd_wr && (slave_cmd == tws_pkg::CMD_RESPONSE);
    // A timeout only fires on a busy bus, so the START that meets it is always a
    // repeated one; a plain START can never land on the timeout cycle.
    assign drop_hit = (ev.start_det || ev.rstart_det) && ev.timeout;

    ////////////////////////////////////////////////////////////////////////////
    // Transaction tracking; a START that meets a timeout is dropped.
    // The drop state waits for the bus to end the lost transaction by a STOP or a plain START.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tws_pkg::TWS_IDLE: begin
                if (drop_hit) begin
                    state_next = tws_pkg::TWS_DROP;
                end else if (ev.start_det) begin
                    state_next = tws_pkg::TWS_ADDR;
                end
            end
            tws_pkg::TWS_ADDR: begin
                if (drop_hit) begin
                    state_next = tws_pkg::TWS_DROP;
                end else if (ev.stop_det || ev.timeout) begin
                    state_next = tws_pkg::TWS_IDLE;
                end else if (addr_match) begin
                    state_next = tws_pkg::TWS_DATA;
                end
            end
            tws_pkg::TWS_DATA: begin
                if (drop_hit) begin
                    state_next = tws_pkg::TWS_DROP;
                end else if (ev.stop_det || ev.timeout) begin
                    state_next = tws_pkg::TWS_IDLE;
                end else if (ev.rstart_det) begin
                    state_next = tws_pkg::TWS_ADDR;
                end
            end
            tws_pkg::TWS_DROP: begin
                if (ev.stop_det || ev.start_det) begin
                    state_next = tws_pkg::TWS_IDLE;
                end
            end
        endcase
    end

    // State register of the transaction tracker.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= tws_pkg::TWS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop/address flag: hardware set wins over the write-one clear.
    // A STOP only raises it when a transaction was live, so an idle STOP stays quiet.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_addr_reg <= 1'b0;
        end else if (addr_set || (ev.stop_det && state_reg != tws_pkg::TWS_IDLE)) begin
            stop_addr_reg <= 1'b1;
        end else if (stop_addr_clr) begin
            stop_addr_reg <= 1'b0;
        end
    end

    // Lock memory: a clear that met an address set leaves the hold stuck.
    // Only a response command or a STOP frees it, as on the flawed silicon.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= 1'b0;
        end else if (lock_hit) begin
            lock_reg <= 1'b1;
        end else if (resp_cmd || ev.stop_det) begin
            lock_reg <= 1'b0;
        end
    end

    // Clock hold sets on address match and releases on clear, response or STOP.
    // The coincident clear is swallowed, so SCL stays low: the lock is kept on purpose,
    // and later clears cannot free it while the lock memory is set.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 1'b0;
        end else if (addr_set || lock_hit) begin
            hold_reg <= 1'b1;
        end else if ((stop_addr_clr && stop_addr_reg && !lock_reg) || resp_cmd || ev.stop_det) begin
            hold_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The response command clears the data flag one cycle late.
    // A read in the cycle right after the command therefore still sees the flag set.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_clr_reg <= 1'b0;
        end else begin
            data_clr_reg <= resp_cmd;
        end
    end

    // Data flag: a new data event wins over the delayed clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_flag_reg <= 1'b0;
        end else if (data_event && state_reg == tws_pkg::TWS_DATA) begin
            data_flag_reg <= 1'b1;
        end else if (data_clr_reg) begin
            data_flag_reg <= 1'b0;
        end
    end

    // Collision flag: only plain START clears it in hardware.
    // Software must clear it after a repeated START, because hardware leaves it standing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txc_reg <= 1'b0;
        end else if (tx_collision) begin
            txc_reg <= 1'b1;
        end else if (ev.start_det || tx_coll_clr) begin
            txc_reg <= 1'b0;
        end
    end

    // One-cycle pulse when a transaction is dropped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_reg <= 1'b0;
        end else begin
            drop_reg <= drop_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // SCL is open drain: low enable means drive low while holding.
    // The data level is fixed low; only the enable says whether the pin is pulled.
    assign scl_out                = 1'b0;
    assign scl_oe_n               = ~hold_reg;
    // Status levels come straight from their flip-flops.
    assign stop_addr_irq_flag     = stop_addr_reg;
    assign data_irq_flag          = data_flag_reg;
    assign tx_coll_flag           = txc_reg;
    assign clock_stretch_hold     = hold_reg;
    assign bus_state_field        = ev.bus_state;
    assign drop_event             = drop_reg;
    // Presence of the two instances is fixed in this revision.
    assign first_serial_instance  = tws_pkg::INST_PRESENT;
    assign second_serial_instance = tws_pkg::INST_ABSENT;
endmodule

//--- design/tws_pkg.sv
// Package with shared constants and types of the two-wire slave flag block.
package tws_pkg;
    localparam logic [1:0] CMD_NONE     = 2'b00;
    localparam logic [1:0] CMD_RESPONSE = 2'b11;
    localparam logic [1:0] BUS_UNKNOWN  = 2'b00;
    localparam logic [1:0] BUS_IDLE     = 2'b01;
    localparam logic [1:0] BUS_OWNER    = 2'b10;
    localparam logic [1:0] BUS_BUSY     = 2'b11;
    localparam int         DATA_CLR_LAT = 1;
    localparam int         TMO_US       = 25;
    localparam int         CLK_MHZ      = 40;
    localparam int         TMO_CYCLES   = TMO_US * CLK_MHZ;
    localparam logic       INST_PRESENT = 1'b1;
    localparam logic       INST_ABSENT  = 1'b0;
    typedef enum logic [1:0] {
        TWS_IDLE = 2'b00,
        TWS_ADDR = 2'b01,
        TWS_DATA = 2'b10,
        TWS_DROP = 2'b11
    } tws_state_t;
endpackage

//--- design/tws_if.sv
// Interface that carries bus events from the front end to the flag logic.
`timescale 1ns/1ps
interface tws_if;
    logic start_det;
    logic rstart_det;
    logic stop_det;
    logic scl_low;
    logic timeout;
    logic [1:0] bus_state;
    modport front (output start_det, rstart_det, stop_det, scl_low, timeout, bus_state);
    modport core  (input  start_det, rstart_det, stop_det, scl_low, timeout, bus_state);
endinterface

//--- design/tws_front.sv
// Bus front end: START, repeated START and STOP detection, bus state and timeout.
`timescale 1ns/1ps
module tws_front #(
    parameter int TMO_CYCLES = tws_pkg::TMO_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic timeout_en,
    tws_if.front      ev
);
    localparam int CW = $clog2(TMO_CYCLES + 1);
    // Refuse a timeout count that the counter cannot serve.
    if (TMO_CYCLES < 1) begin : g_bad_tmo
        $error("timeout count must be at least one");
    end
    logic          scl_reg;
    logic          sda_reg;
    logic          busy_reg;
    logic [1:0]    state_reg;
    logic [CW-1:0] cnt_reg;
    logic          start_c;
    logic          stop_c;
    // Edges of SDA while SCL is high mark START and STOP.
    assign start_c = scl_reg & scl_in & sda_reg & ~sda_in;
    assign stop_c  = scl_reg & scl_in & ~sda_reg & sda_in;
    assign ev.start_det  = start_c & ~busy_reg;
    assign ev.rstart_det = start_c & busy_reg;
    assign ev.stop_det   = stop_c;
    assign ev.scl_low    = ~scl_in;
    assign ev.bus_state  = state_reg;
    assign ev.timeout    = timeout_en && busy_reg && (cnt_reg == CW'(TMO_CYCLES - 1));
    // Sample previous pin levels for edge detection.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl_in;
            sda_reg <= sda_in;
        end
    end
    // Busy tracking; the bus starts unknown until a START shows it busy or a STOP shows it idle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg  <= 1'b0;
            state_reg <= tws_pkg::BUS_UNKNOWN;
        end else if (start_c) begin
            busy_reg  <= 1'b1;
            state_reg <= tws_pkg::BUS_BUSY;
        end else if (stop_c || ev.timeout) begin
            busy_reg  <= 1'b0;
            state_reg <= tws_pkg::BUS_IDLE;
        end
    end
    // Timeout counts cycles of SCL high while busy; any SCL low restarts it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (!busy_reg || !scl_in || ev.timeout) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end
endmodule

//--- verification/tws_checker.sv
// Checker of flag, hold and drop timing at the slave top ports.
`timescale 1ns/1ps
module tws_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       scl_oe_n,
    input wire logic       timeout_en,
    input wire logic       addr_match,
    input wire logic       data_event,
    input wire logic       tx_collision,
    input wire logic [1:0] slave_cmd,
    input wire logic       slave_cmd_wr,
    input wire logic       stop_addr_clr,
    input wire logic       tx_coll_clr,
    input wire logic       stop_addr_irq_flag,
    input wire logic       data_irq_flag,
    input wire logic       tx_coll_flag,
    input wire logic       clock_stretch_hold,
    input wire logic [1:0] bus_state_field,
    input wire logic       drop_event,
    input wire logic       first_serial_instance,
    input wire logic       second_serial_instance
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Response command while the data flag is up.
    sequence s_resp;
        slave_cmd_wr && slave_cmd == tws_pkg::CMD_RESPONSE && data_irq_flag;
    endsequence
    // Hold raised by an address set that met a software clear.
    sequence s_lock;
        $rose(clock_stretch_hold) && $past(stop_addr_clr);
    endsequence
    a_coll_set: assert property (tx_collision |=> tx_coll_flag)
        else $error("collision flag not set");
    // Only a clear or a START from a non-busy bus may drop the flag.
    a_coll_fall_cause: assert property ($fell(tx_coll_flag) |->
        $past(tx_coll_clr) || $past(bus_state_field) != tws_pkg::BUS_BUSY)
        else $error("collision flag dropped in busy bus");
    a_hold_pin: assert property (scl_oe_n != clock_stretch_hold)
        else $error("pin enable differs from hold");
    a_lock_hold: assert property (s_lock ##0 !slave_cmd_wr |=> clock_stretch_hold)
        else $error("locked hold released");
    a_clr_flag: assert property (stop_addr_clr && clock_stretch_hold && !addr_match && !tx_collision
        && !tx_coll_clr |=> !stop_addr_irq_flag && $stable(tx_coll_flag))
        else $error("flag clear wrong");
    a_resp_delay: assert property (s_resp ##0 !data_event |=>
        data_irq_flag ##1 (!data_irq_flag || $past(data_event)))
        else $error("data flag clear timing wrong");
    a_drop_pulse: assert property (drop_event |-> $past(timeout_en) ##1 !drop_event)
        else $error("drop pulse wrong");
    a_inst_fixed: assert property (first_serial_instance && !second_serial_instance)
        else $error("instance presence wrong");
endmodule
////////////////////////////////////////
bind tws_top tws_checker chk (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .scl_oe_n               (scl_oe_n),
    .timeout_en             (timeout_en),
    .addr_match             (addr_match),
    .data_event             (data_event),
    .tx_collision           (tx_collision),
    .slave_cmd              (slave_cmd),
    .slave_cmd_wr           (slave_cmd_wr),
    .stop_addr_clr          (stop_addr_clr),
    .tx_coll_clr            (tx_coll_clr),
    .stop_addr_irq_flag     (stop_addr_irq_flag),
    .data_irq_flag          (data_irq_flag),
    .tx_coll_flag           (tx_coll_flag),
    .clock_stretch_hold     (clock_stretch_hold),
    .bus_state_field        (bus_state_field),
    .drop_event             (drop_event),
    .first_serial_instance  (first_serial_instance),
    .second_serial_instance (second_serial_instance)
);

//--- verification/tws_bus_model.sv
// Model of the other bus parties driving SCL and SDA.
`timescale 1ns/1ps
module tws_bus_model (
    input  wire logic core_clk,
    input  wire logic scl_oe_n,
    output logic      scl_in,
    output logic      sda_in
);
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    // Pull-ups make a wired AND, so a held SCL stays low whatever we drive.
    assign scl_in = scl_drv & scl_oe_n;
    assign sda_in = sda_drv;
    ////////////////////////////////////////
    // Set both lines, then keep them for n falling edges.
    task automatic step(input logic c, input logic d, input int n);
        scl_drv = c;
        sda_drv = d;
        repeat (n) @(negedge core_clk);
    endtask
    // START or repeated START: SDA falls while SCL is high.
    task automatic start_c();
        step(scl_drv, 1'b1, 2);
        step(1'b1, 1'b1, 2);
        step(1'b1, 1'b0, 2);
        step(1'b0, 1'b0, 2);
    endtask
    // STOP: SDA rises while SCL is high.
    task automatic stop_c();
        step(1'b0, 1'b0, 2);
        step(1'b1, 1'b0, 2);
        step(1'b1, 1'b1, 2);
    endtask
endmodule

//--- verification/tws_top_bench.sv
// Self-checking bench of the two-wire slave flag block.
`timescale 1ns/1ps
module tws_top_bench;
    logic       core_clk, rst_n, scl_in, sda_in, scl_out, scl_oe_n, timeout_en;
    logic       addr_match, data_event, tx_collision, slave_cmd_wr, stop_addr_clr, tx_coll_clr;
    logic       stop_addr_irq_flag, data_irq_flag, tx_coll_flag, clock_stretch_hold;
    logic       drop_event, first_serial_instance, second_serial_instance;
    logic [1:0] slave_cmd, bus_state_field;
    int         fails, checks_done, drops, cyc;
    // Rows: collision, clear, address, data, expected collision flag.
    logic [4:0] rows [6] = '{5'h11, 5'h05, 5'h03, 5'h08, 5'h19, 5'h08};
    tws_top #(
        .TMO_CYCLES (8)
    ) uut (
        .core_clk               (core_clk),
        .rst_n                  (rst_n),
        .scl_in                 (scl_in),
        .sda_in                 (sda_in),
        .scl_out                (scl_out),
        .scl_oe_n               (scl_oe_n),
        .timeout_en             (timeout_en),
        .addr_match             (addr_match),
        .data_event             (data_event),
        .tx_collision           (tx_collision),
        .slave_cmd              (slave_cmd),
        .slave_cmd_wr           (slave_cmd_wr),
        .stop_addr_clr          (stop_addr_clr),
        .tx_coll_clr            (tx_coll_clr),
        .stop_addr_irq_flag     (stop_addr_irq_flag),
        .data_irq_flag          (data_irq_flag),
        .tx_coll_flag           (tx_coll_flag),
        .clock_stretch_hold     (clock_stretch_hold),
        .bus_state_field        (bus_state_field),
        .drop_event             (drop_event),
        .first_serial_instance  (first_serial_instance),
        .second_serial_instance (second_serial_instance)
    );
    tws_bus_model m (
        .core_clk (core_clk),
        .scl_oe_n (scl_oe_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in)
    );
    // Clock at 40 MHz.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Watchdog on the run length; also counts drop pulses.
    always @(posedge core_clk) begin
        cyc++;
        if (drop_event === 1'b1) drops++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask
    // Repeated START after SCL stays high for k cycles; one k lands on the timeout cycle.
    task automatic sweep();
        for (int k = 1; k < 15; k++) begin
            m.start_c();
            m.step(1'b0, 1'b1, 1);
            m.step(1'b1, 1'b1, k);
            m.step(1'b1, 1'b0, 3);
            m.stop_c();
        end
    endtask
    task give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        {rst_n, timeout_en, addr_match, data_event, tx_collision, slave_cmd_wr, stop_addr_clr, tx_coll_clr} = '0;
        slave_cmd = tws_pkg::CMD_NONE;
        {fails, checks_done, drops, cyc} = '0;
        repeat (16) @(negedge core_clk);
        chk(8'({scl_out, scl_oe_n, first_serial_instance, second_serial_instance, bus_state_field}), 8'h18);
        chk(8'({stop_addr_irq_flag, data_irq_flag, tx_coll_flag, clock_stretch_hold, drop_event}), 8'h00);
        rst_n = 1'b1;
        $display("Test reset finished");
        // Idle bus: collision set and clear, address and data refused.
        foreach (rows[i]) begin
            {tx_collision, tx_coll_clr, addr_match, data_event} = rows[i][4:1];
            @(negedge core_clk);
            chk(8'({stop_addr_irq_flag, data_irq_flag, tx_coll_flag}), {7'h00, rows[i][0]});
        end
        {tx_collision, tx_coll_clr, addr_match, data_event} = '0;
        $display("Test table finished");
        // Plain START, address hold, clear, response command, repeated START.
        m.stop_c();
        pulse(tx_collision);
        m.start_c();
        chk(8'(tx_coll_flag), 8'h00);
        pulse(tx_collision);
        pulse(addr_match);
        chk(8'({stop_addr_irq_flag, clock_stretch_hold, scl_oe_n}), 8'h06);
        pulse(stop_addr_clr);
        chk(8'({stop_addr_irq_flag, clock_stretch_hold, scl_oe_n, tx_coll_flag}), 8'h03);
        pulse(data_event);
        slave_cmd = tws_pkg::CMD_RESPONSE;
        pulse(slave_cmd_wr);
        chk(8'(data_irq_flag), 8'h01);
        @(negedge core_clk);
        chk(8'(data_irq_flag), 8'h00);
        m.start_c();
        chk(8'(tx_coll_flag), 8'h01);
        pulse(tx_coll_clr);
        chk(8'(tx_coll_flag), 8'h00);
        $display("Test transfer finished");
        // Address set and software clear in one cycle keep SCL held.
        addr_match = 1'b1;
        pulse(stop_addr_clr);
        addr_match = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(8'({stop_addr_irq_flag, clock_stretch_hold, scl_oe_n}), 8'h06);
        pulse(stop_addr_clr);
        chk(8'({clock_stretch_hold, scl_oe_n}), 8'h02);
        pulse(slave_cmd_wr);
        m.stop_c();
        chk(8'({clock_stretch_hold, bus_state_field}), 8'(tws_pkg::BUS_IDLE));
        if (bus_state_field === tws_pkg::BUS_IDLE && clock_stretch_hold === 1'b0) pulse(stop_addr_clr);
        chk(8'(stop_addr_irq_flag), 8'h00);
        $display("Test lock finished");
        // A timeout meeting a START drops it, only while timeout is enabled.
        timeout_en = 1'b1;
        sweep();
        chk(8'(drops > 0), 8'h01);
        timeout_en = 1'b0;
        drops = 0;
        sweep();
        chk(8'(drops > 0), 8'h00);
        $display("Test timeout finished");
        give_verdict();
    end
endmodule
